// ===== dacc_top.sv
// Calibration sequencer, output pipeline and control mode logic.
//
// Function
// - Saturate codes to zeros or ones
// - Shared flag when either channel saturates
// - Each channel demultiplexed 1:2, half rate
// - Calibrate after power-up and on command
// - No calibration start in power-down
// - Command: 80 low then 80 high
// - Pin high at power-up holds calibration
// - Power-up delay two to 25 or 31
// - Power-down at power-up stops delay counter
// - Running flag high during every calibration
// - Latency 13 late, 14 early buses
// - Offset binary output coding
// - Convert every cycle, no start needed
// - Serial mode ignores four configuration pins
// - Pin range high 870, low 650
// - Serial range programmable 560 to 840
// - Mid-supply level equals floating input
// - Output swing normal or reduced
// - Running calibration finishes before power-down
// - Floating edge pin selects DDR
// - SDR edge pin selects rise or fall
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "dacc_consts.svh"
module dacc_top #(
  parameter logic [31:0] DLY_SHORT  = `DACC_DLY_SHORT_CYC,
  parameter logic [31:0] DLY_LONG   = `DACC_DLY_LONG_CYC,
  parameter logic [15:0] CAL_CYCLES = `DACC_CAL_CYC
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [31:0]             wb_dat_i,
  input  wire logic [3:0]              wb_sel_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    trim_request_pin_i,
  input  wire logic                    power_down_pin_i,
  input  wire logic                    serial_mode_pin_i,
  input  wire dacc_pkg::dacc_cfg_pins_s cfg_pins_i,
  input  wire logic [`DACC_IN_W-1:0]   ichan_sample_i,
  input  wire logic [`DACC_IN_W-1:0]   qchan_sample_i,
  output dacc_pkg::dacc_bus_s          out_bus_o,
  output logic                         trim_in_progress_o,
  output logic                         power_down_o,
  output logic                         swing_normal_o,
  output logic                         ddr_mode_o,
  output logic                         edge_rise_o,
  output logic      [9:0]              full_scale_mv_o
);
  import dacc_pkg::*;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Mid-supply reads the same as floating; both count as high.
  function automatic logic lvl_high(input dacc_lvl_e l);
    lvl_high = (l != LVL_LOW);
  endfunction : lvl_high

  function automatic dacc_smp_s enc(input logic [`DACC_IN_W-1:0] v);
    logic signed [`DACC_IN_W:0] b;
    b = $signed({v[`DACC_IN_W-1], v}) + `DACC_CODE_MID;
    if (b < 0)
      enc = '{sat: 1'b1, code: `DACC_CODE_MIN};
    else if (b > `DACC_CODE_TOP)
      enc = '{sat: 1'b1, code: `DACC_CODE_MAX};
    else
      enc = '{sat: 1'b0, code: b[7:0]};
  endfunction : enc

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [`DACC_SYNC_W-1:0] s1_reg;
  logic [`DACC_SYNC_W-1:0] s2_reg;
  logic [`DACC_SYNC_W-1:0] s3_reg;
  logic [`DACC_SYNC_W-1:0] filt_reg;
  wire  [`DACC_SYNC_W-1:0] pins_raw = {trim_request_pin_i, power_down_pin_i,
                                       serial_mode_pin_i, cfg_pins_i};

  genvar gi;
  generate
    for (gi = 0; gi < `DACC_SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge sys_clk_i)
      begin
        if (!rst_n_i)
        begin
          s1_reg[gi]   <= 1'b0;
          s2_reg[gi]   <= 1'b0;
          s3_reg[gi]   <= 1'b0;
          filt_reg[gi] <= 1'b0;
        end
        else
        begin
          s1_reg[gi] <= pins_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi])
            filt_reg[gi] <= s3_reg[gi];
        end
      end
    end
  endgenerate

  wire            trim_s   = filt_reg[10];
  wire            pd_s     = filt_reg[9];
  wire            serial_s = filt_reg[8];
  dacc_cfg_pins_s cfg_s;
  assign cfg_s = filt_reg[7:0];

  // ==========================================================
  // Register file on classic Wishbone
  // ==========================================================
  logic [`DACC_CTRL_W-1:0] ctrl_reg;
  logic [9:0]              fsr_reg;
  logic [9:0]              fsr_next;
  logic                    ack_reg;
  logic [31:0]             rdat_reg;
  dacc_state_e             state_reg;
  logic                    pd_active_reg;
  dacc_bus_s               out_reg;
  wire wb_req = wb_cyc_i && wb_stb_i && !ack_reg;

  always_comb
  begin
    fsr_next = fsr_reg;
    if (wb_sel_i[0])
      fsr_next[7:0] = wb_dat_i[7:0];
    if (wb_sel_i[1])
      fsr_next[9:8] = wb_dat_i[9:8];
    if (fsr_next < `DACC_FSR_MIN)
      fsr_next = `DACC_FSR_MIN;
    else if (fsr_next > `DACC_FSR_MAX)
      fsr_next = `DACC_FSR_MAX;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_reg <= `DACC_CTRL_RST;
      fsr_reg  <= `DACC_FSR_RST;
    end
    else if (wb_req && wb_we_i)
    begin
      if (wb_adr_i == `DACC_ADR_CTRL && wb_sel_i[0])
        ctrl_reg <= wb_dat_i[`DACC_CTRL_W-1:0];
      if (wb_adr_i == `DACC_ADR_FSR)
        fsr_reg <= fsr_next;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg  <= wb_req;
      rdat_reg <= 32'h0000_0000;
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          `DACC_ADR_CTRL:
            rdat_reg[`DACC_CTRL_W-1:0] <= ctrl_reg;
          `DACC_ADR_FSR:
            rdat_reg[9:0] <= fsr_reg;
          `DACC_ADR_STATUS:
          begin
            rdat_reg[`DACC_ST_TRIM]   <= trim_in_progress_o;
            rdat_reg[`DACC_ST_PD]     <= pd_active_reg;
            rdat_reg[`DACC_ST_SERIAL] <= serial_s;
            rdat_reg[`DACC_ST_OOR]    <= out_reg.out_of_range_flag;
            rdat_reg[`DACC_ST_FSM_HI:`DACC_ST_FSM_LO] <= state_reg;
          end
          default:
            rdat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ==========================================================
  // Configuration selection
  // ==========================================================
  // Pins are ignored entirely in serial mode; switching modes while
  // running simply swaps the source, no settling is attempted.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      swing_normal_o  <= 1'b1;
      ddr_mode_o      <= 1'b0;
      edge_rise_o     <= 1'b0;
      full_scale_mv_o <= `DACC_FSR_PIN_LO;
    end
    else if (serial_s)
    begin
      swing_normal_o  <= ctrl_reg[`DACC_CTRL_SWING];
      ddr_mode_o      <= ctrl_reg[`DACC_CTRL_DDR];
      edge_rise_o     <= ctrl_reg[`DACC_CTRL_EDGE];
      full_scale_mv_o <= fsr_reg;
    end
    else
    begin
      swing_normal_o  <= lvl_high(cfg_s.output_swing_select);
      ddr_mode_o      <= (cfg_s.output_transition_edge == LVL_MID);
      edge_rise_o     <= (cfg_s.output_transition_edge == LVL_HIGH);
      full_scale_mv_o <= lvl_high(cfg_s.full_scale_select) ?
                         `DACC_FSR_PIN_HI : `DACC_FSR_PIN_LO;
    end
  end

  wire long_dly = serial_s ? ctrl_reg[`DACC_CTRL_LDLY] :
                  lvl_high(cfg_s.power_up_delay_select);
  wire [31:0] dly_target = long_dly ? DLY_LONG : DLY_SHORT;

  // ==========================================================
  // Calibration command filter
  // ==========================================================
  logic [6:0] lo_cnt_reg;
  logic [6:0] hi_cnt_reg;
  logic       lo_ok_reg;
  wire cmd_pulse = trim_s && lo_ok_reg && !pd_s &&
                   hi_cnt_reg == `DACC_CMD_MIN_CYC - 7'h1;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || pd_s)
    begin
      lo_cnt_reg <= 7'h00;
      hi_cnt_reg <= 7'h00;
      lo_ok_reg  <= 1'b0;
    end
    else if (!trim_s)
    begin
      hi_cnt_reg <= 7'h00;
      if (hi_cnt_reg != 7'h00)
      begin
        lo_ok_reg  <= 1'b0;
        lo_cnt_reg <= 7'h01;
      end
      else if (lo_cnt_reg == `DACC_CMD_MIN_CYC - 7'h1)
        lo_ok_reg <= 1'b1;
      else
        lo_cnt_reg <= lo_cnt_reg + 7'h1;
    end
    else if (!lo_ok_reg)
      lo_cnt_reg <= 7'h00;
    else if (hi_cnt_reg == `DACC_CMD_MIN_CYC - 7'h1)
    begin
      lo_ok_reg  <= 1'b0;
      lo_cnt_reg <= 7'h00;
      hi_cnt_reg <= 7'h00;
    end
    else
      hi_cnt_reg <= hi_cnt_reg + 7'h1;
  end

  // ==========================================================
  // Calibration sequencer
  // ==========================================================
  logic [31:0] dly_cnt_reg;
  logic [15:0] cal_cnt_reg;
  logic [1:0]  settle_reg;
  logic        strap_done_reg;
  logic        strap_hi_reg;

  // The request pin level is caught once the synchroniser has settled.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      settle_reg     <= 2'h0;
      strap_done_reg <= 1'b0;
      strap_hi_reg   <= 1'b0;
    end
    else if (settle_reg != `DACC_SYNC_SETTLE)
      settle_reg <= settle_reg + 2'h1;
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      // The filter output only settles at this very edge, so the strap is
      // taken from the agreeing stages to avoid reading the reset value.
      strap_hi_reg   <= (s2_reg[10] == s3_reg[10]) ? s3_reg[10] :
                        trim_s;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg   <= ST_DELAY;
      dly_cnt_reg <= 32'h0000_0000;
      cal_cnt_reg <= 16'h0000;
    end
    else
    begin
      case (state_reg)
        ST_DELAY:
          if (!pd_s)
          begin
            if (dly_cnt_reg == dly_target - 32'h1)
              state_reg <= strap_hi_reg ? ST_HOLD : ST_CAL;
            else
              dly_cnt_reg <= dly_cnt_reg + 32'h1;
          end
        ST_HOLD:
          if (cmd_pulse)
            state_reg <= ST_CAL;
        ST_IDLE:
          if (cmd_pulse)
            state_reg <= ST_CAL;
        ST_CAL:
          // Power-down is not checked here so the run always completes.
          if (cal_cnt_reg == CAL_CYCLES - 16'h1)
          begin
            state_reg   <= ST_IDLE;
            cal_cnt_reg <= 16'h0000;
          end
          else
            cal_cnt_reg <= cal_cnt_reg + 16'h1;
        default:
          state_reg <= ST_DELAY;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      trim_in_progress_o <= 1'b0;
      pd_active_reg      <= 1'b0;
    end
    else
    begin
      trim_in_progress_o <= (state_reg == ST_CAL);
      pd_active_reg      <= pd_s && (state_reg != ST_CAL);
    end
  end

  assign power_down_o = pd_active_reg;

  // ==========================================================
  // Output pipeline and 1:2 demultiplexer
  // ==========================================================
  dacc_smp_s ipipe [0:`DACC_LAT_EARLY-1];
  dacc_smp_s qpipe [0:`DACC_LAT_EARLY-1];
  logic      phase_reg;
  dacc_smp_s i_enc;
  dacc_smp_s q_enc;
  assign i_enc = enc(ichan_sample_i);
  assign q_enc = enc(qchan_sample_i);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      for (int k = 0; k < `DACC_LAT_EARLY; k++)
      begin
        ipipe[k] <= '0;
        qpipe[k] <= '0;
      end
    end
    else
    begin
      ipipe[0] <= i_enc;
      qpipe[0] <= q_enc;
      for (int k = 1; k < `DACC_LAT_EARLY; k++)
      begin
        ipipe[k] <= ipipe[k-1];
        qpipe[k] <= qpipe[k-1];
      end
    end
  end

  // Both buses load on alternate edges; early carries the older sample.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      phase_reg <= 1'b0;
      out_reg   <= '0;
    end
    else
    begin
      phase_reg <= !phase_reg;
      if (phase_reg && !pd_active_reg)
      begin
        out_reg.ichan_late_bus  <= ipipe[`DACC_LAT_LATE-1].code;
        out_reg.ichan_early_bus <= ipipe[`DACC_LAT_EARLY-1].code;
        out_reg.qchan_late_bus  <= qpipe[`DACC_LAT_LATE-1].code;
        out_reg.qchan_early_bus <= qpipe[`DACC_LAT_EARLY-1].code;
        out_reg.out_of_range_flag <= ipipe[`DACC_LAT_LATE-1].sat |
                                     ipipe[`DACC_LAT_EARLY-1].sat |
                                     qpipe[`DACC_LAT_LATE-1].sat |
                                     qpipe[`DACC_LAT_EARLY-1].sat;
      end
    end
  end

  assign out_bus_o = out_reg;

  // ==========================================================
  // Assertions
  // ==========================================================
  // Counts edges since reset so latency checks skip the unfilled pipeline.
  logic [4:0] fill_reg;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      fill_reg <= 5'h00;
    else if (fill_reg != 5'h1F)
      fill_reg <= fill_reg + 5'h01;
  end

  logic [7:0] hi_run_reg;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || !trim_s)
      hi_run_reg <= 8'h00;
    else if (hi_run_reg != 8'hFF)
      hi_run_reg <= hi_run_reg + 8'h1;
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_SAT: assert property (
    ($signed(ichan_sample_i) < -$signed(`DACC_CODE_MID)) |=>
    (ipipe[0].code == `DACC_CODE_MIN && ipipe[0].sat))
    else $error("Low overrange not coded as zero.");
  AST_OOR: assert property (
    fill_reg > 5'(`DACC_LAT_EARLY) &&
    $past(phase_reg && !pd_active_reg) &&
    $past(i_enc.sat, `DACC_LAT_EARLY) |->
    out_reg.out_of_range_flag)
    else $error("Out of range flag missing.");
  AST_LAT_LATE: assert property (
    fill_reg > 5'(`DACC_LAT_EARLY) &&
    $past(phase_reg && !pd_active_reg) |->
    out_reg.ichan_late_bus == $past(i_enc.code, `DACC_LAT_EARLY))
    else $error("Late bus latency wrong.");
  AST_LAT_EARLY: assert property (
    fill_reg > 5'(`DACC_LAT_EARLY) &&
    $past(phase_reg && !pd_active_reg) |->
    out_reg.qchan_early_bus == $past(q_enc.code, `DACC_LAT_EARLY + 1))
    else $error("Early bus latency wrong.");
  AST_DEMUX: assert property (
    !$past(phase_reg) |-> $stable(out_reg))
    else $error("Bus changed on a skip cycle.");
  AST_NO_PD_START: assert property (
    $rose(trim_in_progress_o) |-> !$past(pd_s, 2))
    else $error("Calibration started in power-down.");
  AST_CMD: assert property (
    cmd_pulse |-> hi_run_reg >= 8'h4F ##1 state_reg == ST_CAL)
    else $error("Command taken too early.");
  AST_RUN: assert property (
    state_reg == ST_CAL |=> trim_in_progress_o)
    else $error("Running flag low during calibration.");
  AST_PD_STOP: assert property (
    state_reg == ST_DELAY && pd_s |=> $stable(dly_cnt_reg))
    else $error("Delay counter ran in power-down.");
  AST_FINISH: assert property (
    state_reg == ST_CAL && pd_s |=> !pd_active_reg)
    else $error("Power-down entered mid calibration.");
  AST_END: assert property (
    state_reg == ST_CAL && cal_cnt_reg == CAL_CYCLES - 16'h1 |=>
    state_reg == ST_IDLE ##1 !trim_in_progress_o)
    else $error("Calibration did not return to idle.");
  AST_SERIAL: assert property (
    serial_s && $stable(serial_s) |=>
    ddr_mode_o == $past(ctrl_reg[`DACC_CTRL_DDR]))
    else $error("Pin used in serial mode.");

  COV_POWERUP_CAL: cover property (state_reg == ST_DELAY ##1
                                   state_reg == ST_CAL);
  COV_CMD_CAL: cover property (state_reg == ST_IDLE && cmd_pulse);
  COV_HOLD: cover property (state_reg == ST_HOLD ##1 state_reg == ST_CAL);
  COV_OOR: cover property ($rose(out_reg.out_of_range_flag));
endmodule : dacc_top

// ===== dacc_consts.svh
// Constants for the dual converter calibration and output control block.
`ifndef DACC_CONSTS_SVH
`define DACC_CONSTS_SVH
`define DACC_ADR_CTRL      8'h00
`define DACC_ADR_STATUS    8'h04
`define DACC_ADR_FSR       8'h08
`define DACC_CTRL_SWING    0
`define DACC_CTRL_DDR      1
`define DACC_CTRL_EDGE     2
`define DACC_CTRL_LDLY     3
`define DACC_CTRL_W        4
`define DACC_CTRL_RST      4'h1
`define DACC_ST_TRIM       0
`define DACC_ST_PD         1
`define DACC_ST_SERIAL     2
`define DACC_ST_OOR        3
`define DACC_ST_FSM_LO     4
`define DACC_ST_FSM_HI     7
`define DACC_FSR_RST       10'h2BC
`define DACC_FSR_MIN       10'h230
`define DACC_FSR_MAX       10'h348
`define DACC_FSR_PIN_HI    10'h366
`define DACC_FSR_PIN_LO    10'h28A
`define DACC_DLY_SHORT_CYC 32'h0200_0000
`define DACC_DLY_LONG_CYC  32'h8000_0000
`define DACC_CAL_CYC       16'h0400
`define DACC_CMD_MIN_CYC   7'h50
`define DACC_LAT_LATE      13
`define DACC_LAT_EARLY     14
`define DACC_SYNC_SETTLE   2'h3
`define DACC_IN_W          10
`define DACC_CODE_MID      11'sh080
`define DACC_CODE_TOP      11'sh0FF
`define DACC_CODE_MIN      8'h00
`define DACC_CODE_MAX      8'hFF
`define DACC_SYNC_W        11
`endif

// ===== dacc_pkg.sv
// Types shared by the dual converter calibration and output control block.
package dacc_pkg;
  typedef enum logic [1:0] {
    LVL_LOW  = 2'b00,
    LVL_HIGH = 2'b01,
    LVL_MID  = 2'b10
  } dacc_lvl_e;
  typedef enum logic [3:0] {
    ST_DELAY = 4'b0001,
    ST_HOLD  = 4'b0010,
    ST_IDLE  = 4'b0100,
    ST_CAL   = 4'b1000
  } dacc_state_e;
  typedef struct packed {
    logic       sat;
    logic [7:0] code;
  } dacc_smp_s;
  typedef struct packed {
    logic [7:0] ichan_late_bus;
    logic [7:0] ichan_early_bus;
    logic [7:0] qchan_late_bus;
    logic [7:0] qchan_early_bus;
    logic       out_of_range_flag;
  } dacc_bus_s;
  typedef struct packed {
    dacc_lvl_e output_swing_select;
    dacc_lvl_e output_transition_edge;
    dacc_lvl_e full_scale_select;
    dacc_lvl_e power_up_delay_select;
  } dacc_cfg_pins_s;
endpackage : dacc_pkg

// ===== dacc_capture_model.sv
// Capture model that interleaves the demultiplexed I buses to full rate.
`timescale 1ns/1ps
module dacc_capture_model (
  input  wire logic                sys_clk_i,
  input  wire logic                rst_n_i,
  input  wire dacc_pkg::dacc_bus_s out_bus_i,
  output logic [7:0]               word_o
);
  import dacc_pkg::*;
  logic       take_reg;
  logic [7:0] late_reg;
  // ====================
  // Interleaving.
  // Taking the words one edge after each load keeps clear of the change.
  always_ff @(posedge sys_clk_i)
  begin
    take_reg <= rst_n_i ? ~take_reg : 1'b0;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_n_i && !take_reg)
    begin
      word_o   <= out_bus_i.ichan_early_bus;
      late_reg <= out_bus_i.ichan_late_bus;
    end
    else
    begin
      word_o <= late_reg;
    end
  end
endmodule : dacc_capture_model

// ===== test_dacc_top.sv
// Self-checking bench for the calibration and output control block.
`timescale 1ns/1ps
`define CK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s expected %h seen %h", n, e, g); end end
module test_dacc_top;
  import dacc_pkg::*;
  localparam int DS = 16;
  localparam int DL = 32;
  localparam int CAL = 8;
  logic              clk = 1'b0, rst_n = 1'b0, trim = 1'b0, pd = 1'b0;
  logic              cyc = 1'b0, stb = 1'b0, we = 1'b0, ser = 1'b0;
  logic [7:0]        adr = 8'h00, iw;
  logic [31:0]       wdat = 32'h0, rdat;
  logic signed [9:0] ich = 10'h0, qch = 10'h0, hi [64], hq [64];
  dacc_cfg_pins_s    cfg = 8'h00;
  dacc_bus_s         bus;
  logic [9:0]        fs_o;
  logic              ack, trim_o, pd_o, swing_o, ddr_o, edge_o, chk = 1'b0;
  int                miscompares = 0, cmp_count = 0;
  int                starts = 0, run = 0, last_len = 0, m = 0;
  dacc_top #(.DLY_SHORT(32'(DS)), .DLY_LONG(32'(DL)),
    .CAL_CYCLES(16'(CAL))) u_dut (
    .sys_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
    .wb_dat_o(rdat), .wb_ack_o(ack), .trim_request_pin_i(trim),
    .power_down_pin_i(pd), .serial_mode_pin_i(ser), .cfg_pins_i(cfg),
    .ichan_sample_i(ich), .qchan_sample_i(qch), .out_bus_o(bus),
    .trim_in_progress_o(trim_o), .power_down_o(pd_o),
    .swing_normal_o(swing_o), .ddr_mode_o(ddr_o), .edge_rise_o(edge_o),
    .full_scale_mv_o(fs_o));
  dacc_capture_model u_cap (.sys_clk_i(clk), .rst_n_i(rst_n),
    .out_bus_i(bus), .word_o(iw));
  function automatic logic [7:0] cd(input logic signed [9:0] v);
    return v < -10'sh080 ? 8'h00 : v > 10'sh07F ? 8'hFF : 8'(v + 10'sh080);
  endfunction : cd
  function automatic logic st(input logic signed [9:0] v);
    return v < -10'sh080 || v > 10'sh07F;
  endfunction : st
  // ====================
  // Monitors.
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (trim_o === 1'b1 && run == 0) starts++;
    if (trim_o === 1'b1) run++;
    else if (run != 0)
    begin
      last_len = run;
      run = 0;
    end
  end
  // Loads land on even edge counts, so l is the load that the bus shows.
  always @(posedge clk)
  begin : out_chk
    int   l;
    logic r;
    l = m - m % 2;
    r = st(hi[(l-13)%64]) | st(hi[(l-14)%64]) | st(hq[(l-13)%64]) |
        st(hq[(l-14)%64]);
    if (chk && m >= 18)
    begin
      `CK("i_late", cd(hi[(l-13)%64]), bus.ichan_late_bus)
      `CK("i_early", cd(hi[(l-14)%64]), bus.ichan_early_bus)
      `CK("q_late", cd(hq[(l-13)%64]), bus.qchan_late_bus)
      `CK("q_early", cd(hq[(l-14)%64]), bus.qchan_early_bus)
      `CK("range", r, bus.out_of_range_flag)
      `CK("stream", cd(hi[(m-15)%64]), iw)
    end
    if (!rst_n) m <= 0;
    else
    begin
      m <= m + 1;
      hi[(m+1)%64] <= ich;
      hq[(m+1)%64] <= qch;
    end
  end
  // ====================
  // Drivers.
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles
  task automatic rst_dut;
    @(posedge clk);
    rst_n <= 1'b0;
    cycles(8);
    rst_n <= 1'b1;
  endtask : rst_dut
  task automatic wb(input logic w_en, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    `CK("ack", 1'b1, ack)
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wait_cal(output int n);
    n = 0;
    while (trim_o !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_cal
  task automatic pulse(input int lo, input int hi_n);
    trim <= 1'b0;
    cycles(lo);
    trim <= 1'b1;
    cycles(hi_n);
  endtask : pulse
  // ====================
  // Scenarios.
  task automatic t_out;
    rst_dut();
    chk = 1'b1;
    for (int k = 0; k < 160; k++)
    begin
      @(posedge clk);
      ich <= 10'((k * 37) % 400 - 200);
      qch <= 10'(150 - (k * 53) % 400);
    end
    chk = 1'b0;
    $display("t_out done");
  endtask : t_out
  task automatic t_pwr;
    int n;
    for (int d = 0; d < 2; d++)
    begin
      cfg.power_up_delay_select <= d ? LVL_HIGH : LVL_LOW;
      rst_dut();
      wait_cal(n);
      `CK("pu_delay", 1'b1, n >= (d ? DL : DS) && n <= (d ? DL : DS) + 12)
      cycles(20);
      `CK("cal_len", CAL, last_len)
    end
    $display("t_pwr done");
  endtask : t_pwr
  task automatic t_cmd;
    int s;
    trim <= 1'b1;
    rst_dut();
    s = starts;
    cycles(80);
    `CK("strap_hold", 0, starts - s)
    pulse(79, 100);
    `CK("short_low", 0, starts - s)
    pulse(90, 79);
    `CK("short_high", 0, starts - s)
    pulse(85, 90);
    cycles(20);
    `CK("command", 1, starts - s)
    $display("t_cmd done");
  endtask : t_cmd
  task automatic t_pd;
    int s;
    int n;
    cfg.power_up_delay_select <= LVL_LOW;
    trim <= 1'b0;
    pd <= 1'b1;
    rst_dut();
    s = starts;
    cycles(60);
    `CK("pd_delay", 0, starts - s)
    `CK("pd_out", 1'b1, pd_o)
    pulse(90, 90);
    `CK("pd_cmd", 0, starts - s)
    pd <= 1'b0;
    wait_cal(n);
    `CK("pd_resume", 1'b1, n >= 8 && n <= DS + 12)
    cycles(20);
    pulse(85, 0);
    wait_cal(n);
    pd <= 1'b1;
    cycles(6);
    `CK("pd_gated", 1'b0, pd_o)
    cycles(20);
    `CK("pd_len", CAL, last_len)
    `CK("pd_after", 1'b1, pd_o)
    s = starts;
    pulse(90, 90);
    cycles(4);
    `CK("pd_idle_cmd", 0, starts - s)
    pd <= 1'b0;
    $display("t_pd done");
  endtask : t_pd
  task automatic t_cfg;
    int s;
    for (int i = 0; i < 3; i++)
    begin
      cfg <= {4{2'(i)}};
      cycles(8);
      `CK("fsr_pin", i != 0 ? 10'h366 : 10'h28A, fs_o)
      `CK("swing", i != 0, swing_o)
      `CK("ddr", i == 2, ddr_o)
      if (i < 2) `CK("edge", i == 1, edge_o)
    end
    // The range pin changed above, so a fresh calibration is requested.
    s = starts;
    pulse(85, 90);
    cycles(4);
    `CK("recal", 1, starts - s)
    $display("t_cfg done");
  endtask : t_cfg
  task automatic t_reg;
    logic [31:0] q;
    // The control mode follows the synchronised pin at any time; here it is set before the reset.
    ser <= 1'b1;
    rst_dut();
    wb(1'b0, 8'h08, 32'h0, q);
    `CK("fsr_rst", 32'h2BC, q)
    wb(1'b0, 8'h0C, 32'h0, q);
    `CK("unmapped", 32'h0, q)
    wb(1'b1, 8'h08, 32'h3FF, q);
    wb(1'b0, 8'h08, 32'h0, q);
    `CK("fsr_max", 32'h348, q)
    wb(1'b1, 8'h08, 32'h100, q);
    wb(1'b1, 8'h00, 32'h4, q);
    cycles(8);
    `CK("fsr_ser", 10'h230, fs_o)
    `CK("swing_ser", 1'b0, swing_o)
    `CK("ddr_ser", 1'b0, ddr_o)
    `CK("edge_ser", 1'b1, edge_o)
    $display("t_reg done");
  endtask : t_reg
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    #(25 * 5000);
    miscompares++;
    wrap_up();
  end
  initial
  begin
    t_out();
    t_pwr();
    t_cmd();
    t_pd();
    t_cfg();
    t_reg();
    wrap_up();
  end
endmodule : test_dacc_top
